// file: hdl/gate_driver_status_regs.sv
// Purpose: Overvoltage flags and switching measurement registers
// Assumes: Reads arrive as a one-cycle strobe with address
// Notes: Read data follows one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module gate_driver_status_regs
	import gate_status_pkg::*;
#(
	parameter int BRIDGES = 3
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	input wire logic restart,
	input wire logic [FLAG_W-1:0] ov_event,
	input wire logic [MEAS_N-1:0] meas_load,
	input wire measurement_type [MEAS_N-1:0] meas_value,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic rd_unmapped,
	output logic [FLAG_W-1:0] ov_flags
);
	// Index 0..2 delay per bridge, 3..5 slope per bridge
	if (BRIDGES != 3) begin : g_bad_bridges
		$error("BRIDGES must be 3 to match the register map");
	end

	function automatic logic [2:0] addr_select(
		input logic [ADDR_W-1:0] a);
		logic [2:0] s;
		case (a)
			ADDR_DELAY1: s = 3'h0;
			ADDR_DELAY2: s = 3'h1; // RULE11
			ADDR_DELAY3: s = 3'h2;
			ADDR_SLOPE1: s = 3'h3;
			ADDR_SLOPE2: s = 3'h4;
			ADDR_SLOPE3: s = 3'h5;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction

	function automatic logic is_flag_addr(
		input logic [ADDR_W-1:0] a);
		return a == ADDR_OVERVOLTAGE; // RULE10
	endfunction

	measurement_type [MEAS_N-1:0] meas;

	genvar gi;
	for (gi = 0; gi < MEAS_N; gi++) begin : g_meas
		measurement_register u_meas (
			.clk(clk),
			.reset_n(reset_n),
			.soft_reset(soft_reset),
			.restart(restart),
			.load(meas_load[gi]),
			.value(meas_value[gi]),
			.stored(meas[gi])
		);
	end

	// Flag register group
	logic [FLAG_W-1:0] next_ov_flags;
	logic flag_read;
	logic [DATA_W-1:0] flag_word;

	always_comb begin
		flag_read = rd_en && is_flag_addr(rd_addr);
		flag_word = RESET_VALUE;
		flag_word[FLAG_W-1:0] = ov_flags;
		next_ov_flags = ov_flags;
		if (soft_reset) begin
			next_ov_flags = '0; // RULE3
		end else begin
			if (restart) begin
				// Only out-of-range bits are dropped here
				next_ov_flags = ov_flags &
					OV_RESTART_KEEP[FLAG_W-1:0]; // RULE2
			end
			if (flag_read) begin
				next_ov_flags = '0; // RULE1
			end
			// A new event beats the clear of the same cycle
			next_ov_flags = next_ov_flags | ov_event; // RULE1
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ov_flags <= '0;
		end else begin
			ov_flags <= next_ov_flags;
		end
	end

	// Read answer group
	logic [DATA_W-1:0] next_rd_data;
	logic next_rd_valid;
	logic next_rd_unmapped;
	logic [2:0] sel;

	always_comb begin
		sel = addr_select(rd_addr);
		next_rd_data = RESET_VALUE;
		next_rd_valid = rd_en;
		next_rd_unmapped = 1'b0;
		if (rd_en) begin
			if (is_flag_addr(rd_addr)) begin
				next_rd_data = flag_word; // RULE1
			end else if (sel != SEL_NONE) begin
				// Reserved bits come out zero by packing
				next_rd_data = pack_word(meas[sel]); // RULE9
			end else begin
				next_rd_unmapped = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
			rd_valid <= 1'b0;
			rd_unmapped <= 1'b0;
		end else begin
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
			rd_unmapped <= next_rd_unmapped;
		end
	end

	// Checks
	a_flag_sets: assert property ( // RULE1
		@(posedge clk) disable iff (!reset_n)
		(!soft_reset && ov_event[4]) |=> ov_flags[4])
		else $error("Overvoltage event did not set its flag");

	a_read_clears: assert property ( // RULE1
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_OVERVOLTAGE && ov_event == '0)
		|=> ov_flags == '0)
		else $error("Flag read did not clear the flags");

	a_read_returns: assert property ( // RULE10
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_OVERVOLTAGE && !soft_reset)
		|=> rd_valid && rd_data[5:0] == $past(ov_flags)
			&& rd_data[15:6] == 10'h000)
		else $error("Flag read returned wrong data");

	a_restart_keeps: assert property ( // RULE2
		@(posedge clk) disable iff (!reset_n)
		(restart && !soft_reset && !rd_en && ov_event == '0)
		|=> $stable(ov_flags))
		else $error("Restart changed the overvoltage flags");

	a_soft_clears: assert property ( // RULE3
		@(posedge clk) disable iff (!reset_n)
		soft_reset |=> ov_flags == '0 && meas == '0)
		else $error("Soft reset left a register set");

	a_meas_restart: assert property ( // RULE4
		@(posedge clk) disable iff (!reset_n)
		(restart && !soft_reset && meas_load == '0)
		|=> $stable(meas))
		else $error("Restart changed a measurement");

	a_off_delay: assert property ( // RULE5
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_DELAY1)
		|=> rd_data[13:8] == $past(meas[0].upper))
		else $error("Turn-off delay read wrong");

	a_on_delay: assert property ( // RULE6
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_DELAY3)
		|=> rd_data[5:0] == $past(meas[2].lower))
		else $error("Turn-on delay read wrong");

	a_fall_time: assert property ( // RULE7
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_SLOPE2)
		|=> rd_data[13:8] == $past(meas[4].upper))
		else $error("Fall time read wrong");

	a_rise_time: assert property ( // RULE8
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_SLOPE3)
		|=> rd_data[5:0] == $past(meas[5].lower))
		else $error("Rise time read wrong");

	a_reserved_zero: assert property ( // RULE9
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr >= ADDR_DELAY1 && rd_addr <= ADDR_SLOPE3)
		|=> rd_data[15:14] == 2'b00 && rd_data[7:6] == 2'b00)
		else $error("Reserved measurement bits not zero");

	a_bridge2_delay: assert property ( // RULE11
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_DELAY2)
		|=> rd_data == {2'b00, $past(meas[1].upper),
			2'b00, $past(meas[1].lower)})
		else $error("Bridge 2 delay layout wrong");

	a_load_reads: assert property ( // RULE5
		@(posedge clk) disable iff (!reset_n)
		(meas_load[0] && !soft_reset) ##1
		(rd_en && rd_addr == ADDR_DELAY1 && meas_load == '0)
		|=> rd_data[13:8] == $past(meas_value[0].upper, 2))
		else $error("Loaded delay not read back");

	// Flag side: set wins over the clear of the same cycle
	a_set_beats_clear: assert property ( // RULE1
		@(posedge clk) disable iff (!reset_n)
		(rd_en && is_flag_addr(rd_addr) && !soft_reset && ov_event != '0)
		|=> ov_flags == $past(ov_event))
		else $error("Event lost to a flag read clear");

	a_flags_hold: assert property ( // RULE1
		@(posedge clk) disable iff (!reset_n)
		(!soft_reset && !(rd_en && is_flag_addr(rd_addr))
			&& ov_event == '0) |=> $stable(ov_flags))
		else $error("Flags changed with no event or read");

	a_restart_flags: assert property ( // RULE2
		@(posedge clk) disable iff (!reset_n)
		(restart && !soft_reset && !(rd_en && is_flag_addr(rd_addr)))
		|=> ov_flags == ($past(ov_flags) | $past(ov_event)))
		else $error("Restart dropped a flag or an event");

	a_soft_beats_event: assert property ( // RULE3
		@(posedge clk) disable iff (!reset_n)
		(soft_reset && ov_event != '0) |=> ov_flags == '0)
		else $error("Event survived a soft reset");

	// Every index checked, so a miswired load strobe shows up
	for (gi = 0; gi < MEAS_N; gi++) begin : g_load_check
		a_load_stores: assert property ( // RULE11
			@(posedge clk) disable iff (!reset_n)
			(meas_load[gi] && !soft_reset)
			|=> meas[gi] == $past(meas_value[gi]))
			else $error("Measurement load not stored");
	end

	a_read_answers: assert property ( // RULE10
		@(posedge clk) disable iff (!reset_n)
		rd_en |=> rd_valid)
		else $error("Read strobe got no answer");

	a_idle_quiet: assert property ( // RULE9
		@(posedge clk) disable iff (!reset_n)
		!rd_en |=> !rd_valid && !rd_unmapped && rd_data == RESET_VALUE)
		else $error("Read port active with no read");

	a_unmapped_zero: assert property ( // RULE10
		@(posedge clk) disable iff (!reset_n)
		(rd_en && !is_flag_addr(rd_addr) && addr_select(rd_addr) == SEL_NONE)
		|=> rd_unmapped && rd_data == RESET_VALUE)
		else $error("Unmapped read not refused");

	a_mapped_known: assert property ( // RULE10
		@(posedge clk) disable iff (!reset_n)
		(rd_en && (is_flag_addr(rd_addr) || addr_select(rd_addr) != SEL_NONE))
		|=> !rd_unmapped)
		else $error("Mapped read flagged as unmapped");

	a_delay1_layout: assert property ( // RULE5
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_DELAY1)
		|=> rd_data == {2'b00, $past(meas[0].upper),
			2'b00, $past(meas[0].lower)})
		else $error("Bridge 1 delay layout wrong");

	a_on_delay1: assert property ( // RULE6
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_DELAY1)
		|=> rd_data[5:0] == $past(meas[0].lower))
		else $error("Bridge 1 turn-on delay read wrong");

	a_off_delay3: assert property ( // RULE5
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_DELAY3)
		|=> rd_data[13:8] == $past(meas[2].upper))
		else $error("Bridge 3 turn-off delay read wrong");

	a_fall_time1: assert property ( // RULE7
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_SLOPE1)
		|=> rd_data[13:8] == $past(meas[3].upper))
		else $error("Bridge 1 fall time read wrong");

	a_rise_time1: assert property ( // RULE8
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_SLOPE1)
		|=> rd_data[5:0] == $past(meas[3].lower))
		else $error("Bridge 1 rise time read wrong");

	a_rise_time2: assert property ( // RULE8
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_SLOPE2)
		|=> rd_data[5:0] == $past(meas[4].lower))
		else $error("Bridge 2 rise time read wrong");

	a_fall_time3: assert property ( // RULE7
		@(posedge clk) disable iff (!reset_n)
		(rd_en && rd_addr == ADDR_SLOPE3)
		|=> rd_data[13:8] == $past(meas[5].upper))
		else $error("Bridge 3 fall time read wrong");
endmodule
`default_nettype wire

// file: shared/gate_status_pkg.sv
// Purpose: Constants and types for the gate driver status registers
// Assumes: 16-bit registers reached by a 7-bit register address
// Notes: How it works is listed below
// How it works
// [RULE1] Six switch overvoltage flags, cleared when read
// [RULE2] Restart clears overvoltage bits 15,11,7,6 only
// [RULE3] Soft reset clears all registers to zero
// [RULE4] Restart keeps measurement fields, clears reserved bits
// [RULE5] Turn-off delay count in bits 13:8
// [RULE6] Turn-on delay count in bits 5:0
// [RULE7] Fall time count in bits 13:8
// [RULE8] Rise time count in bits 5:0
// [RULE9] Measurement reserved bits always read zero
// [RULE10] Overvoltage register sits at address 101_0010
// [RULE11] Bridge 2 delays laid out like bridges 1, 3
package gate_status_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int COUNT_W = 6;
	localparam int FLAG_W = 6;
	localparam int MEAS_N = 6;
	// Scale of one count step, in tenths of a ns
	localparam int STEP_TENTH_NS = 533;
	localparam logic [ADDR_W-1:0] ADDR_OVERVOLTAGE = 7'h52;
	localparam logic [ADDR_W-1:0] ADDR_DELAY1 = 7'h53;
	localparam logic [ADDR_W-1:0] ADDR_DELAY2 = 7'h54;
	localparam logic [ADDR_W-1:0] ADDR_DELAY3 = 7'h55;
	localparam logic [ADDR_W-1:0] ADDR_SLOPE1 = 7'h56;
	localparam logic [ADDR_W-1:0] ADDR_SLOPE2 = 7'h57;
	localparam logic [ADDR_W-1:0] ADDR_SLOPE3 = 7'h58;
	localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
	localparam logic [DATA_W-1:0] OV_RESTART_KEEP = 16'h773f;
	localparam logic [DATA_W-1:0] MEAS_RESTART_KEEP = 16'h3f3f;
	localparam int UPPER_LSB = 8;
	localparam int LOWER_LSB = 0;
	localparam logic [2:0] SEL_NONE = 3'h7;

	typedef struct packed {
		logic [COUNT_W-1:0] upper;
		logic [COUNT_W-1:0] lower;
	} measurement_type;

	function automatic logic [DATA_W-1:0] pack_word(
		input measurement_type m);
		logic [DATA_W-1:0] w;
		w = RESET_VALUE;
		w[UPPER_LSB +: COUNT_W] = m.upper; // RULE5 RULE7
		w[LOWER_LSB +: COUNT_W] = m.lower; // RULE6 RULE8
		return w;
	endfunction

	function automatic measurement_type unpack_word(
		input logic [DATA_W-1:0] w);
		measurement_type m;
		m.upper = w[UPPER_LSB +: COUNT_W];
		m.lower = w[LOWER_LSB +: COUNT_W];
		return m;
	endfunction
endpackage

// file: hdl/measurement_register.sv
// Purpose: One read-only measurement register with two count fields
// Assumes: Load, restart and soft reset are synchronous pulses
// Notes: Soft reset has priority over load and restart
`timescale 1ns/1ps
`default_nettype none
module measurement_register
	import gate_status_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	input wire logic restart,
	input wire logic load,
	input wire measurement_type value,
	output measurement_type stored
);
	measurement_type next_stored;

	always_comb begin
		next_stored = stored;
		if (soft_reset) begin
			next_stored = unpack_word(RESET_VALUE); // RULE3
		end else if (load) begin
			next_stored = value;
		end else if (restart) begin
			// Fields survive, reserved bits are never stored
			next_stored = unpack_word(pack_word(stored) &
				MEAS_RESTART_KEEP); // RULE4
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stored <= '0;
		end else begin
			stored <= next_stored;
		end
	end
endmodule
`default_nettype wire

// file: tb/host_reader.sv
// Purpose: Host model reading one status word per request
// Assumes: Answer stands for one cycle, one cycle after the strobe
// Notes: Released address is scrambled, not left at its last value
`timescale 1ns/1ps
`default_nettype none
module host_reader
	import gate_status_pkg::*;
(
	input wire logic clk,
	output logic rd_en,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic rd_valid,
	input wire logic rd_unmapped
);
	initial begin
		rd_en = 1'b0;
		rd_addr = 7'h00;
	end
	task automatic read(input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d, output logic u, output logic v);
		@(negedge clk);
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clk);
		rd_en = 1'b0;
		rd_addr = ~a;
		d = rd_data;
		u = rd_unmapped;
		v = rd_valid;
	endtask
endmodule
`default_nettype wire

// file: tb/gate_driver_status_regs_tb.sv
// Purpose: Self-checking bench for the status registers
// Assumes: Host reads go through the host model task
// Notes: Inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module gate_driver_status_regs_tb;
	import gate_status_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic soft_reset = 1'b0;
	logic restart = 1'b0;
	logic [FLAG_W-1:0] ov_event = '0;
	logic [MEAS_N-1:0] meas_load = '0;
	measurement_type [MEAS_N-1:0] meas_value = '0;
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic rd_valid;
	logic rd_unmapped;
	logic [FLAG_W-1:0] ov_flags;
	logic [DATA_W-1:0] expect_word [MEAS_N];
	int fail_count = 0;
	int checked = 0;

	gate_driver_status_regs #(.BRIDGES(3)) i_gate_driver_status_regs (
		.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
		.restart(restart), .ov_event(ov_event), .meas_load(meas_load),
		.meas_value(meas_value), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_valid(rd_valid),
		.rd_unmapped(rd_unmapped), .ov_flags(ov_flags));
	host_reader i_host_reader (.clk(clk), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
		.rd_unmapped(rd_unmapped));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] got, exp, input string s);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
		end
	endtask

	task automatic read_check(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] exp, input logic exp_unm);
		logic [DATA_W-1:0] d;
		logic u;
		logic v;
		i_host_reader.read(a, d, u, v);
		check(d, exp, "read data");
		check({14'h0000, v, u}, {14'h0000, 1'b1, exp_unm}, "read status");
	endtask

	task automatic pulse(input logic [FLAG_W-1:0] e, input logic rs,
		input logic sr);
		@(negedge clk);
		ov_event = e;
		restart = rs;
		soft_reset = sr;
		@(negedge clk);
		ov_event = '0;
		restart = 1'b0;
		soft_reset = 1'b0;
	endtask

	task automatic read_all(input logic zero);
		logic [DATA_W-1:0] e;
		for (int i = 0; i < MEAS_N; i++) begin
			e = zero ? RESET_VALUE : expect_word[i];
			read_check(ADDR_W'(ADDR_DELAY1 + i), e, 1'b0);
		end
	endtask

	// Generous bound: the whole sequence needs about 130 of the 5000 cycles
	initial begin
		#(100 * 5000);
		fail_count++;
		close_out();
	end

	initial begin
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		read_check(ADDR_OVERVOLTAGE, RESET_VALUE, 1'b0);
		read_all(1'b1);
		read_check(7'h60, RESET_VALUE, 1'b1);
		for (int i = 0; i < FLAG_W; i++) begin
			pulse(6'h01 << i, 1'b0, 1'b0);
			check(16'(ov_flags), 16'h0001 << i, "flag out");
			read_check(ADDR_OVERVOLTAGE, 16'h0001 << i, 1'b0);
			read_check(ADDR_OVERVOLTAGE, RESET_VALUE, 1'b0);
		end
		// Event and clearing read in one cycle: the event must win
		fork
			read_check(ADDR_OVERVOLTAGE, RESET_VALUE, 1'b0);
			pulse(6'h08, 1'b0, 1'b0);
		join
		check(16'(ov_flags), 16'h0008, "set beats clear");
		read_check(ADDR_OVERVOLTAGE, 16'h0008, 1'b0);
		for (int i = 0; i < MEAS_N; i++) begin
			meas_value[i].upper = 6'(33 + i);
			meas_value[i].lower = 6'(63 - i);
			expect_word[i] = {2'b00, meas_value[i].upper, 2'b00,
				meas_value[i].lower};
		end
		@(negedge clk);
		meas_load = '1;
		// Read right behind the load edge, no idle cycle between
		fork
			read_check(ADDR_DELAY1, expect_word[0], 1'b0);
			begin
				@(negedge clk);
				meas_load = '0;
			end
		join
		read_all(1'b0);
		pulse(6'h15, 1'b0, 1'b0);
		pulse(6'h00, 1'b1, 1'b0);
		check(16'(ov_flags), 16'h0015, "flags after restart");
		read_check(ADDR_OVERVOLTAGE, 16'h0015, 1'b0);
		read_all(1'b0);
		pulse(6'h2a, 1'b0, 1'b0);
		pulse(6'h01, 1'b0, 1'b1);
		check(16'(ov_flags), RESET_VALUE, "flags after soft reset");
		read_check(ADDR_OVERVOLTAGE, RESET_VALUE, 1'b0);
		read_all(1'b1);
		// Mid-run hard reset with every register holding a value
		pulse(6'h3f, 1'b0, 1'b0);
		@(negedge clk);
		meas_load = '1;
		@(negedge clk);
		meas_load = '0;
		reset_n = 1'b0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		check(16'(ov_flags), RESET_VALUE, "flags after reset");
		read_check(ADDR_OVERVOLTAGE, RESET_VALUE, 1'b0);
		read_all(1'b1);
		close_out();
	end
endmodule
`default_nettype wire
